//--- core/phy_status_map.vh
`ifndef PHY_STATUS_MAP_VH
`define PHY_STATUS_MAP_VH
// Register indices (management space) and byte addresses on APB
`define IDX_BASIC_MODE_STATUS 5'h01
`define IDX_AUTONEG_EXPANSION 5'h06
`define IDX_INTERRUPT_STATUS_EVENT 5'h12
`define IDX_FALSE_CARRIER_COUNT 5'h14
`define IDX_PHY_STATUS_SUMMARY 5'h10
`define ADDR_PHY_STATUS_SUMMARY 8'h40
`define ADDR_SRC_READ 8'h80
`define ADDR_CONFIG 8'h84
`define ADDR_IRQ_STATUS 8'h88
`define ADDR_IRQ_CLEAR 8'h8c
`define ADDR_IRQ_ENABLE 8'h90
// Summary field positions
`define BIT_POLARITY 12
`define BIT_FALSE_CARRIER 11
`define BIT_SIGNAL_DETECT 10
`define BIT_DESCR_LOCK 9
`define BIT_PAGE_RX 8
`define BIT_IRQ_PENDING 7
`define BIT_REMOTE_FAULT 6
`define BIT_JABBER 5
`define BIT_AN_DONE 4
`define BIT_LOOPBACK 3
`define BIT_DUPLEX 2
`define BIT_SPEED10 1
`define BIT_LINK 0
// Config register: bit 0 qualifies signal detect with lock
`define CFG_SD_QUAL 0
`define CFG_RESET 1'b0
// Interrupt status layout
`define IRQ_FALSE_CARRIER 0
`define IRQ_REMOTE_FAULT 1
`define IRQ_LOST_SIGNAL 2
`define IRQ_WIDTH 3
`endif

//--- core/sticky_flag.v
`timescale 1ns/100ps
// Sticky flag: set wins over clear in the same cycle
module sticky_flag #(
   parameter SET_VAL = 1'b1
) (
   input wire clk_i,
   input wire nrst_i,
   input wire set_i,
   input wire clr_i,
   output reg flag_o
);
   always @(posedge clk_i)
   begin
      if (!nrst_i)
         flag_o <= ~SET_VAL;
      else if (set_i)
         flag_o <= SET_VAL;
      else if (clr_i)
         flag_o <= ~SET_VAL;
   end
endmodule

//--- core/apb_slave_port.v
`timescale 1ns/100ps
// Zero-wait APB decode: one-cycle strobes in the access phase
module apb_slave_port (
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [7:0] match_i,
   output wire rd_o,
   output wire wr_o
);
   wire hit;
   assign hit = psel_i & penable_i & (paddr_i == match_i);
   assign rd_o = hit & ~pwrite_i;
   assign wr_o = hit & pwrite_i;
endmodule

//--- core/phy_status_summary.v
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "phy_status_map.vh"
// Behaviour
// - Summary register sits at management index 10h (byte 40h on APB).
// - Bit 12 is 1 for inverted receive polarity, 0 for correct polarity.
// - Bit 11 latches high on false carrier; clears on read of register 14h.
// - Bit 10 latching-low signal detect, ANDed with lock when qualify bit set.
// - Bit 9 latching-low 100 Mb/s descrambler lock.
// - Bit 8 latches high on page received; cleared only by read of register 06h or reset.
// - Bit 7 is 1 while interrupt pending; read of 12h clears it.
// - Bit 6 sets on partner remote fault; clears on read of 01h or reset.
// - Bit 5 latches high on jabber detect; clears on read of 01h, summary read leaves it set.
// - Bit 4 is 1 once autonegotiation completed.
// - Bit 3 is 1 while loopback enabled.
// - Bit 2 shows resolved duplex, 1 full, 0 half.
// - Bit 1 shows resolved speed, 1 for 10 Mb/s, 0 for 100 Mb/s.
// - Bit 0 copies link status; summary read does not clear it.
module phy_status_summary (
   input wire clk_i,
   input wire nrst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire polarity_inverted_i,
   input wire false_carrier_evt_i,
   input wire signal_detect_raw_i,
   input wire descr_lock_i,
   input wire page_rx_evt_i,
   input wire irq_evt_i,
   input wire remote_fault_evt_i,
   input wire jabber_evt_i,
   input wire an_done_i,
   input wire loopback_i,
   input wire full_duplex_i,
   input wire speed10_i,
   input wire link_up_i,
   output reg irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   reg cfg;
   reg [`IRQ_WIDTH-1:0] irq_en;
   wire [`IRQ_WIDTH-1:0] irq_stat;
   wire access;
   wire summ_rd;
   wire src_wr;
   wire cfg_wr;
   wire clr_wr;
   wire en_wr;
   reg rd_basic;
   reg rd_aneg;
   reg rd_int;
   reg rd_fc;
   wire sd_qual;
   wire fc_l;
   wire sd_l;
   wire lk_l;
   wire pg_l;
   wire ip_l;
   wire rf_l;
   wire jb_l;
   wire lk_drop;
   reg lk_prev;
   wire [15:0] summary;
   reg [31:0] next_prdata;
   reg next_err;
   wire rd_phase;
   wire wr_phase;
   reg next_ready;
   reg next_slverr;
   reg [31:0] next_rdata;
   reg next_cfg;
   reg [`IRQ_WIDTH-1:0] next_irq_en;
   reg next_irq;

   assign access = psel_i & penable_i;
   // Reads capture and re-arm on the first access edge, together, so a drop
   // landing between capture and re-arm cannot be lost; writes land on the
   // completing edge, once per transfer.
   assign rd_phase = penable_i & ~pready_o;
   assign wr_phase = penable_i & pready_o;

   apb_slave_port u_summ (
      .psel_i(psel_i),
      .penable_i(rd_phase),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .match_i(`ADDR_PHY_STATUS_SUMMARY),
      .rd_o(summ_rd),
      .wr_o()
   );
   apb_slave_port u_src (
      .psel_i(psel_i),
      .penable_i(wr_phase),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .match_i(`ADDR_SRC_READ),
      .rd_o(),
      .wr_o(src_wr)
   );
   apb_slave_port u_cfg (
      .psel_i(psel_i),
      .penable_i(wr_phase),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .match_i(`ADDR_CONFIG),
      .rd_o(),
      .wr_o(cfg_wr)
   );
   apb_slave_port u_clr (
      .psel_i(psel_i),
      .penable_i(wr_phase),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .match_i(`ADDR_IRQ_CLEAR),
      .rd_o(),
      .wr_o(clr_wr)
   );
   apb_slave_port u_en (
      .psel_i(psel_i),
      .penable_i(wr_phase),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .match_i(`ADDR_IRQ_ENABLE),
      .rd_o(),
      .wr_o(en_wr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Source-register reads are reported by the management logic as a write of
   // the read index to the source-read port; summary reads never appear here.
   // Index 10h has no entry: a summary read clears nothing elsewhere
   always @*
   begin
      rd_basic = 1'b0;
      rd_aneg = 1'b0;
      rd_int = 1'b0;
      rd_fc = 1'b0;
      if (src_wr)
      begin
         case (pwdata_i[4:0])
            `IDX_BASIC_MODE_STATUS: rd_basic = 1'b1;
            `IDX_AUTONEG_EXPANSION: rd_aneg = 1'b1;
            `IDX_INTERRUPT_STATUS_EVENT: rd_int = 1'b1;
            `IDX_FALSE_CARRIER_COUNT: rd_fc = 1'b1;
            default: rd_fc = 1'b0;
         endcase
      end
   end

   assign sd_qual = cfg ? (signal_detect_raw_i & descr_lock_i) : signal_detect_raw_i;

   // Latching-low bits re-arm on a summary read; a low that arrives with the
   // read still wins so the drop is never lost.
   sticky_flag #(.SET_VAL(1'b0)) u_sd (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(~sd_qual),
      .clr_i(summ_rd),
      .flag_o(sd_l)
   );
   sticky_flag #(.SET_VAL(1'b0)) u_lock (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(~descr_lock_i),
      .clr_i(summ_rd),
      .flag_o(lk_l)
   );
   sticky_flag u_fc (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(false_carrier_evt_i),
      .clr_i(rd_fc),
      .flag_o(fc_l)
   );
   sticky_flag u_pg (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(page_rx_evt_i),
      .clr_i(rd_aneg),
      .flag_o(pg_l)
   );
   sticky_flag u_ip (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(irq_evt_i),
      .clr_i(rd_int),
      .flag_o(ip_l)
   );
   sticky_flag u_rf (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(remote_fault_evt_i),
      .clr_i(rd_basic),
      .flag_o(rf_l)
   );
   sticky_flag u_jb (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(jabber_evt_i),
      .clr_i(rd_basic),
      .flag_o(jb_l)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Upper three bits belong elsewhere and read as zero here
   assign summary = {3'h0,
      polarity_inverted_i,
      fc_l,
      sd_l,
      lk_l,
      pg_l,
      ip_l,
      rf_l,
      jb_l,
      an_done_i,
      loopback_i,
      full_duplex_i,
      speed10_i,
      link_up_i};

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt events
   assign lk_drop = lk_prev & ~link_up_i;
   sticky_flag u_irq_fc (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(false_carrier_evt_i),
      .clr_i(clr_wr & pwdata_i[`IRQ_FALSE_CARRIER]),
      .flag_o(irq_stat[`IRQ_FALSE_CARRIER])
   );

   sticky_flag u_irq_rf (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(remote_fault_evt_i),
      .clr_i(clr_wr & pwdata_i[`IRQ_REMOTE_FAULT]),
      .flag_o(irq_stat[`IRQ_REMOTE_FAULT])
   );

   sticky_flag u_irq_ld (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(lk_drop),
      .clr_i(clr_wr & pwdata_i[`IRQ_LOST_SIGNAL]),
      .flag_o(irq_stat[`IRQ_LOST_SIGNAL])
   );

   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         lk_prev <= 1'b0;
         cfg <= `CFG_RESET;
         irq_en <= {`IRQ_WIDTH{1'b0}};
         irq_o <= 1'b0;
      end
      else
      begin
         lk_prev <= link_up_i;
         cfg <= next_cfg;
         irq_en <= next_irq_en;
         irq_o <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; a summary write is accepted and discarded
   always @*
   begin
      next_prdata = 32'h0;
      next_err = 1'b0;
      case (paddr_i)
         `ADDR_PHY_STATUS_SUMMARY: next_prdata = {16'h0, summary};
         `ADDR_SRC_READ: next_prdata = 32'h0;
         `ADDR_CONFIG: next_prdata = {31'h0, cfg};
         `ADDR_IRQ_STATUS: next_prdata = {29'h0, irq_stat};
         `ADDR_IRQ_CLEAR: next_prdata = 32'h0;
         `ADDR_IRQ_ENABLE: next_prdata = {29'h0, irq_en};
         default: next_err = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next values of the registered outputs and control registers
   always @*
   begin
      next_ready = access & ~pready_o;
      next_slverr = access & ~pready_o & next_err;
      next_rdata = prdata_o;
      if (psel_i & rd_phase & ~pwrite_i)
         next_rdata = next_prdata;
      next_cfg = cfg;
      if (cfg_wr)
         next_cfg = pwdata_i[`CFG_SD_QUAL];
      next_irq_en = irq_en;
      if (en_wr)
         next_irq_en = pwdata_i[`IRQ_WIDTH-1:0];
      next_irq = |(irq_stat & irq_en);
   end

   // One wait state: pready rises in the second access cycle
   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0;
      end
      else
      begin
         pready_o <= next_ready;
         pslverr_o <= next_slverr;
         prdata_o <= next_rdata;
      end
   end
endmodule

//--- test/phy_status_summary_props.sv
`timescale 1ns/100ps
module phy_status_summary_props (
   input wire clk_i,
   input wire nrst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire polarity_inverted_i,
   input wire false_carrier_evt_i,
   input wire signal_detect_raw_i,
   input wire descr_lock_i,
   input wire link_up_i
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   wire rd = pready_o && !pwrite_i && paddr_i == 8'h40;
   a_ready_one_wait: assert property (psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o ##1 !pready_o)
      else $error("ready timing wrong");
   a_err_unmapped: assert property (pready_o |-> pslverr_o == !(paddr_i inside {8'h40, 8'h80, 8'h84, 8'h88, 8'h8c, 8'h90}))
      else $error("error response wrong");
   a_err_alone: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_upper_zero: assert property (rd |-> prdata_o[31:13] == 19'h0)
      else $error("upper bits not zero");
   a_live_bits: assert property (rd |-> prdata_o[12] == $past(polarity_inverted_i) && prdata_o[0] == $past(link_up_i))
      else $error("live bit wrong");
   a_fc_latched: assert property (rd && $past(false_carrier_evt_i, 2) |-> prdata_o[11])
      else $error("false carrier lost");
   a_sd_low: assert property (rd && !$past(signal_detect_raw_i, 2) |-> !prdata_o[10])
      else $error("signal detect high");
   a_lock_low: assert property (rd && !$past(descr_lock_i, 2) |-> !prdata_o[9])
      else $error("lock high");
endmodule
bind phy_status_summary phy_status_summary_props u_props (
   .clk_i(clk_i),
   .nrst_i(nrst_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .pwrite_i(pwrite_i),
   .paddr_i(paddr_i),
   .prdata_o(prdata_o),
   .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .polarity_inverted_i(polarity_inverted_i),
   .false_carrier_evt_i(false_carrier_evt_i),
   .signal_detect_raw_i(signal_detect_raw_i),
   .descr_lock_i(descr_lock_i),
   .link_up_i(link_up_i)
);

//--- test/testbench.sv
`timescale 1ns/100ps
module testbench;
reg clk_i = 1'b0;
reg nrst_i = 1'b0;
reg psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
reg [7:0] paddr_i = 8'h00;
reg [31:0] pwdata_i = 32'h0, rd;
reg [12:0] st = 13'h0;
wire [31:0] prdata_o;
wire pready_o, pslverr_o, irq_o;
integer num_errors = 0, total_checks = 0, cyc = 0, i;
always #4 clk_i = ~clk_i;
phy_status_summary u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .polarity_inverted_i(st[12]), .false_carrier_evt_i(st[11]),
   .signal_detect_raw_i(st[10]), .descr_lock_i(st[9]), .page_rx_evt_i(st[8]), .irq_evt_i(st[7]),
   .remote_fault_evt_i(st[6]), .jabber_evt_i(st[5]), .an_done_i(st[4]), .loopback_i(st[3]),
   .full_duplex_i(st[2]), .speed10_i(st[1]), .link_up_i(st[0]), .irq_o(irq_o));
////////////////////////////////////////////////////////////////////////
task report_and_stop;
   begin
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
endtask
always @(posedge clk_i)
begin
   cyc = cyc + 1;
   if (cyc == 5000)
   begin
      num_errors = num_errors + 1;
      report_and_stop;
   end
end
task chk(input [31:0] got, input [31:0] exp);
   begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
endtask
// Ready is judged at the rising edge; an idle edge follows every transfer
task apb(input w, input [7:0] a, input [31:0] d, input e);
   begin
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1)
         @(posedge clk_i);
      rd = prdata_o;
      chk(pslverr_o, e);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   end
endtask
task rdc(input [7:0] a, input [31:0] exp);
   begin
      apb(1'b0, a, 32'h0, 1'b0);
      chk(rd, exp);
   end
endtask
task pulse(input [12:0] v, input [12:0] idle);
   begin
      st <= v;
      @(posedge clk_i);
      st <= idle;
   end
endtask
task irq_is(input e);
   begin
      repeat (3) @(posedge clk_i);
      chk(irq_o, e);
   end
endtask
////////////////////////////////////////////////////////////////////////
task t_live;
   begin
      for (i = 0; i < 2; i = i + 1)
      begin
         st <= i ? 13'h0015 : 13'h101b;
         rdc(8'h40, i ? 32'h0015 : 32'h101b);
         apb(1'b1, 8'h40, 32'hffffffff, 1'b0);
         rdc(8'h40, i ? 32'h0015 : 32'h101b);
      end
   end
endtask
// The event stands through the first read, so the latch is seen at once
task t_one(input integer b, input [4:0] idx);
   begin
      st <= 13'h1 << b;
      rdc(8'h40, 32'h1 << b);
      st <= 13'h0;
      rdc(8'h40, 32'h1 << b);
      apb(1'b1, 8'h80, {27'h0, idx}, 1'b0);
      rdc(8'h40, 32'h0);
   end
endtask
task t_latch;
   begin
      t_one(11, 5'h14);
      t_one(8, 5'h06);
      t_one(7, 5'h12);
      t_one(6, 5'h01);
      t_one(5, 5'h01);
   end
endtask
// Latched-low bits start low, so the first read only re-arms them
task t_low;
   begin
      st <= 13'h0600;
      apb(1'b0, 8'h40, 32'h0, 1'b0);
      rdc(8'h40, 32'h0600);
      pulse(13'h0200, 13'h0600);
      rdc(8'h40, 32'h0200);
      pulse(13'h0400, 13'h0600);
      rdc(8'h40, 32'h0400);
      apb(1'b1, 8'h84, 32'h1, 1'b0);
      rdc(8'h84, 32'h1);
      pulse(13'h0400, 13'h0600);
      rdc(8'h40, 32'h0);
      rdc(8'h40, 32'h0600);
      apb(1'b1, 8'h84, 32'h0, 1'b0);
      st <= 13'h0;
   end
endtask
task t_irq;
   begin
      apb(1'b1, 8'h8c, 32'h7, 1'b0);
      apb(1'b1, 8'h90, 32'h1, 1'b0);
      rdc(8'h90, 32'h1);
      pulse(13'h0800, 13'h0);
      irq_is(1'b1);
      rdc(8'h40, 32'h0800);
      rdc(8'h88, 32'h1);
      apb(1'b1, 8'h8c, 32'h1, 1'b0);
      irq_is(1'b0);
      pulse(13'h0040, 13'h0);
      irq_is(1'b0);
      rdc(8'h88, 32'h2);
      apb(1'b0, 8'h44, 32'h0, 1'b1);
   end
endtask
initial
begin
   repeat (2) @(posedge clk_i);
   nrst_i <= 1'b1;
   rdc(8'h40, 32'h0);
   t_live;
   t_latch;
   t_low;
   t_irq;
   report_and_stop;
end
endmodule
